// ---- hw/ssp_core.sv ----
// Serial host port and power sequencing of a low-power motion sensor.
// Assumes the host keeps the documented command gaps; sclk, cs and mosi arrive asynchronously.
// What this block does
// - Soft reset write leads to valid motion within 50 ms.
// - Writing rest-mode select enters the selected rest mode within 1 s.
// - Clearing rest-mode select leaves rest and restores motion within 1 s.
// - Power-control bit 1 requests power down; low current within 50 ms.
// - Writing 0x5A to wake key ends power down; motion after 50 to 55 ms.
// - MISO changes after falling SCLK and holds until the next falling edge.
// - MOSI is sampled on rising SCLK.
// - MISO released to high impedance within 250 ns of chip select rising.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"

module ssp_core #(
  parameter int unsigned RST_MOTION_CYC = `SSP_MS_CYCLES(`SSP_RST_MOTION_MS),
  parameter int unsigned PD_ENTRY_CYC   = `SSP_MS_CYCLES(`SSP_PD_ENTRY_MS),
  parameter int unsigned WAKE_CYC       = `SSP_MS_CYCLES(`SSP_WAKE_MS),
  parameter int unsigned REST_CYC       = `SSP_MS_CYCLES(`SSP_REST_MS)
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Serial port pins.
  input  wire logic       sclk,
  input  wire logic       chip_select_low,
  input  wire logic       mosi,
  output var  logic       miso_o,
  output var  logic       miso_oe,
  // Sensor core status.
  output var  logic       motion_valid,
  output var  logic       low_current,
  output var  logic [1:0] rest_mode_select,
  output var  ssp_pkg::ssp_pwr_t power_state
);
  import ssp_pkg::*;

  ssp_state_t q;
  ssp_state_t d;

  logic       rise;
  logic       fall;
  logic       cs_act;
  logic [7:0] byte_in;
  logic [7:0] rd_data;

  assign rise    = q.sclk_s[1] & ~q.sclk_prev;
  assign fall    = ~q.sclk_s[1] & q.sclk_prev;
  assign cs_act  = ~q.cs_n_s[1];
  assign byte_in = {q.shift_in[6:0], q.mosi_s[1]};

  // Read-back mux; unmapped addresses read as zero.
  always_comb
  begin
    case (q.addr)
      `SSP_REG_POWER_CTRL: rd_data = q.power_ctrl;
      `SSP_REG_REST_CTRL:  rd_data = {6'h00, q.rest_sel};
      `SSP_REG_STATUS:     rd_data = {4'h0, q.pwr, q.low_current, q.motion_valid};
      default:             rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    d           = q;
    // Two-stage synchronisers; only the second stage feeds the edge and data logic.
    d.sclk_s    = {q.sclk_s[0], sclk};
    d.cs_n_s    = {q.cs_n_s[0], chip_select_low};
    d.mosi_s    = {q.mosi_s[0], mosi};
    d.sclk_prev = q.sclk_s[1];
    if (q.timer != 32'h0)
      d.timer = q.timer - 32'h1;

    // Timer expiry is settled before the serial logic so that a command completing in the
    // same cycle overrides it; otherwise the motion flag held up while active would survive
    // a power-down or soft-reset write.
    if (q.timer == 32'h0)
    begin
      case (q.pwr)
        SSP_PWR_DOWN:   d.low_current  = 1'b1;
        SSP_PWR_REST:   d.low_current  = 1'b0;
        SSP_PWR_WAKING:
        begin
          d.motion_valid = 1'b1;
          d.low_current  = 1'b0;
          d.pwr          = SSP_PWR_ACTIVE;
        end
        SSP_PWR_ACTIVE: d.motion_valid = 1'b1;
        default:        d.pwr          = SSP_PWR_ACTIVE;
      endcase
    end

    if (!cs_act)
    begin
      // Releasing three cycles after deselect (two sync stages, then the enable register) keeps well inside the 250 ns bound.
      d.ser      = SSP_SER_ADDR;
      d.bit_cnt  = 3'h0;
      d.miso_oe  = 1'b0;
    end
    else
    begin
      // The data line is driven for the whole select, so the host never sees it float mid-byte.
      d.miso_oe = 1'b1;
      if (rise)
      begin
        d.shift_in = byte_in;
        d.bit_cnt  = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'h7)
        begin
          if (q.ser == SSP_SER_ADDR)
          begin
            d.is_write  = byte_in[7];
            d.addr      = byte_in[6:0];
            d.shift_out = 8'h00;
            d.ser       = SSP_SER_DATA;
          end
          else if (q.ser == SSP_SER_DATA)
          begin
            d.ser = SSP_SER_DONE;
            if (q.is_write)
            begin
              case (q.addr)
                `SSP_REG_POWER_CTRL:
                begin
                  d.power_ctrl = byte_in;
                  if (byte_in[`SSP_PD_BIT])
                  begin
                    d.pwr   = SSP_PWR_DOWN;
                    d.timer = PD_ENTRY_CYC;
                    d.motion_valid = 1'b0;
                  end
                end
                // A wake key outside power down is refused and has no effect.
                `SSP_REG_WAKE_KEY:
                  if (byte_in == `SSP_WAKE_KEY_VALUE && q.pwr == SSP_PWR_DOWN)
                  begin
                    d.power_ctrl[`SSP_PD_BIT] = 1'b0;
                    d.pwr         = SSP_PWR_WAKING;
                    d.timer       = WAKE_CYC;
                    d.low_current = 1'b0;
                  end
                `SSP_REG_REST_CTRL:
                begin
                  // Any rest command also ends power down, so low current drops with it.
                  d.rest_sel = byte_in[1:0];
                  d.low_current = 1'b0;
                  d.timer    = REST_CYC;
                  d.pwr      = (byte_in[1:0] != 2'h0) ? SSP_PWR_REST : SSP_PWR_WAKING;
                  d.motion_valid = 1'b0;
                end
                // Only the reset key takes effect; any other value is ignored.
                `SSP_REG_SOFT_RESET:
                  if (byte_in == `SSP_RESET_KEY_VALUE)
                  begin
                    d.power_ctrl   = 8'h00;
                    d.rest_sel     = 2'h0;
                    d.low_current  = 1'b0;
                    d.motion_valid = 1'b0;
                    d.pwr          = SSP_PWR_WAKING;
                    d.timer        = RST_MOTION_CYC;
                  end
                default: ;
              endcase
            end
          end
        end
      end
      if (fall)
      begin
        // Loading at the first falling edge of the data byte presents the MSB.
        if (q.ser == SSP_SER_DATA && q.bit_cnt == 3'h0 && !q.is_write)
        begin
          d.miso      = rd_data[7];
          d.shift_out = {rd_data[6:0], 1'b0};
        end
        else
        begin
          d.miso      = q.shift_out[7];
          d.shift_out = {q.shift_out[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Clock and select pins idle high, so seeding their synchronisers high avoids a false edge after reset.
      q        <= '0;
      q.sclk_s <= 2'b11;
      q.cs_n_s <= 2'b11;
      q.sclk_prev <= 1'b1;
      q.pwr    <= SSP_PWR_WAKING;
      q.timer  <= 32'h0;
    end
    else
      q <= d;
  end

  assign miso_o           = q.miso;
  assign miso_oe          = q.miso_oe;
  assign motion_valid     = q.motion_valid;
  assign low_current      = q.low_current;
  assign rest_mode_select = q.rest_sel;
  assign power_state      = q.pwr;

endmodule : ssp_core

`default_nettype wire

// ---- hw/ssp_defines.svh ----
// Offsets, field positions, command keys and timing counts of the serial port block.
// Assumes a 40 MHz core clock; times are kept in their own unit and turned into cycles here.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_CLK_MHZ          40
`define SSP_REG_POWER_CTRL   7'h0D
`define SSP_REG_WAKE_KEY     7'h3A
`define SSP_REG_SOFT_RESET   7'h3B
`define SSP_REG_STATUS       7'h02
`define SSP_REG_REST_CTRL    7'h0F
`define SSP_PD_BIT           1
`define SSP_WAKE_KEY_VALUE   8'h5A
`define SSP_RESET_KEY_VALUE  8'h5A
`define SSP_RST_MOTION_MS    30
`define SSP_PD_ENTRY_MS      10
`define SSP_WAKE_MS          52
`define SSP_REST_MS          500
`define SSP_MS_CYCLES(ms)    ((ms) * 1000 * `SSP_CLK_MHZ)

`endif

// ---- hw/ssp_pkg.sv ----
// Types shared by the serial port block.
// Holds no constants beyond the state encodings; other numeric values live in ssp_defines.svh.
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_PWR_ACTIVE = 2'b00,
    SSP_PWR_REST   = 2'b01,
    SSP_PWR_DOWN   = 2'b10,
    SSP_PWR_WAKING = 2'b11
  } ssp_pwr_t;

  typedef enum logic [1:0] {
    SSP_SER_ADDR = 2'b00,
    SSP_SER_DATA = 2'b01,
    SSP_SER_DONE = 2'b10
  } ssp_ser_t;

  typedef struct packed {
    logic [1:0]  sclk_s;
    logic [1:0]  cs_n_s;
    logic [1:0]  mosi_s;
    logic        sclk_prev;
    ssp_ser_t    ser;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic        is_write;
    logic [6:0]  addr;
    logic [7:0]  power_ctrl;
    logic [1:0]  rest_sel;
    ssp_pwr_t    pwr;
    logic [31:0] timer;
    logic        motion_valid;
    logic        low_current;
    logic        miso;
    logic        miso_oe;
  } ssp_state_t;

endpackage : ssp_pkg

// ---- sim/ssp_core_assertions.sv ----
// Port-level checker for the serial port and power sequencing block.
// Sees only the core's ports and is bound to every ssp_core.
`timescale 1ns/1ps
`default_nettype none
module ssp_core_assertions (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Serial port pins.
  input wire logic       sclk,
  input wire logic       chip_select_low,
  input wire logic       mosi,
  input wire logic       miso_o,
  input wire logic       miso_oe,
  // Sensor core status.
  input wire logic       motion_valid,
  input wire logic       low_current,
  input wire logic [1:0] rest_mode_select,
  input wire ssp_pkg::ssp_pwr_t power_state
);
  import ssp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles since the last falling serial clock, saturating so it never wraps into a false pass.
  logic [3:0] fall_age_q;
  always_ff @(posedge clk)
    fall_age_q <= (sys_rst || !$fell(sclk)) ? (sys_rst ? 4'hF : fall_age_q + {3'h0, fall_age_q != 4'hF}) : 4'h0;
  chk_oe_release: assert property ($rose(chip_select_low) |-> ##[1:10] !miso_oe)
    else $error("data out still driven after deselect");
  chk_oe_idle: assert property (chip_select_low [*8] |-> !miso_oe)
    else $error("data out driven while deselected");
  chk_miso_fall: assert property (miso_oe && $stable(miso_oe) && $changed(miso_o) |-> fall_age_q <= 4'h6)
    else $error("data out changed away from a falling clock");
  chk_oe_select: assert property ($rose(miso_oe) |-> !chip_select_low)
    else $error("data out enabled without select");
  chk_low_down: assert property ($rose(low_current) |-> power_state == SSP_PWR_DOWN)
    else $error("low current outside power down");
  chk_low_motion: assert property (low_current |-> !motion_valid)
    else $error("motion valid in low current");
  chk_motion_active: assert property (motion_valid |-> power_state == SSP_PWR_ACTIVE)
    else $error("motion valid while not active");
  chk_rest_select: assert property ($rose(power_state == SSP_PWR_REST) |-> rest_mode_select != 2'h0)
    else $error("rest entered without a rest select");
endmodule : ssp_core_assertions
bind ssp_core ssp_core_assertions u_chk (.*);
`default_nettype wire

// ---- sim/ssp_host_model.sv ----
// Host side of the serial port: drives select, clock and data in.
// Assumes each transfer is started shortly after a core clock edge.
`timescale 1ns/1ps
`default_nettype none
module ssp_host_model (
  // Serial port pins.
  output var  logic sclk,
  output var  logic chip_select_low,
  output var  logic mosi,
  input  wire logic miso
);
  event last_rise;
  initial
  begin
    sclk = 1'b1;
    chip_select_low = 1'b1;
    mosi = 1'b0;
  end
  // Sends nb bits of w, MSB first; read data is sampled just before the next falling clock.
  task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] q);
    chip_select_low = 1'b0;
    #120;
    for (int i = 15; i > 15 - nb; i--)
    begin
      sclk = 1'b0;
      mosi = w[i];
      #100;
      sclk = 1'b1;
      if (i == 0) -> last_rise;
      #99;
      q = {q[6:0], miso};
      #1;
      if (i == 8 && !w[15]) #4000;
    end
    if (w[15]) #20000; else #20;
    chip_select_low = 1'b1;
    mosi = ~mosi;
    #250;
    if (w[15]) #10000;
  endtask : xfer
endmodule : ssp_host_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the serial port and power sequencing block.
// Assumes 20 core cycles stand for one millisecond of the sensor's timers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssp_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  wire  logic sclk;
  wire  logic chip_select_low;
  wire  logic mosi;
  logic       miso_o;
  logic       miso_oe;
  logic       mv;
  logic       lc;
  logic [1:0] rms;
  ssp_pwr_t   ps;
  logic [7:0] q;
  int         fail_count = 0;
  int         compares = 0;
  int         cycles = 0;
  // A released data line shows the inverse of its last level, never a lucky match.
  wire  logic miso_w = miso_oe ? miso_o : ~miso_o;
  always #12.5 clk = ~clk;
  ssp_core #(.RST_MOTION_CYC(600), .PD_ENTRY_CYC(200), .WAKE_CYC(1040), .REST_CYC(10000)) uut (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .chip_select_low(chip_select_low), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .motion_valid(mv), .low_current(lc),
    .rest_mode_select(rms), .power_state(ps));
  ssp_host_model host (.sclk(sclk), .chip_select_low(chip_select_low), .mosi(mosi), .miso(miso_w));
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic check(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic probe(input int s);
    return s == 0 ? mv : (s == 1 ? lc : ps == SSP_PWR_REST);
  endfunction : probe
  // Counts cycles from the last rising clock of a command until the watched status appears.
  task automatic cmd(input logic [15:0] w, input int s, input int lo, input int hi);
    int n;
    logic [7:0] d;
    n = 8;
    @(posedge clk);
    #2;
    fork
      host.xfer(w, 16, d);
      if (hi > 0)
      begin
        @(host.last_rise);
        repeat (8) @(posedge clk);
        #1;
        while (probe(s) !== 1'b1 && n <= hi)
        begin
          @(posedge clk);
          #1;
          n++;
        end
        check(n >= lo && n <= hi, 16'(n), 16'(hi));
      end
    join
    if (!w[15])
      check(d === 8'(lo), {8'h00, d}, 16'(lo));
    $display("test done %h", w);
  endtask : cmd
  initial
  begin
    repeat (20) @(posedge clk);
    #2 sys_rst = 1'b0;
    cmd(16'h8D02, 1, 8, 1000);
    cmd(16'h0D00, 3, 8'h02, 0);
    cmd(16'hBA5A, 0, 1000, 1100);
    cmd(16'h8F01, 2, 8, 20000);
    check(rms === 2'h1, {14'h0, rms}, 16'h0001);
    cmd(16'h0F00, 3, 8'h01, 0);
    cmd(16'h8F00, 0, 8, 20000);
    check(rms === 2'h0, {14'h0, rms}, 16'h0000);
    cmd(16'hBB5A, 0, 8, 1000);
    host.xfer(16'hFFFF, 5, q);
    check(miso_oe === 1'b0, {15'h0, miso_oe}, 16'h0000);
    cmd(16'h0200, 3, 8'h01, 0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
